// >>> hw/psh_map.vh
// Operation
// R01: standby tri-states the switch outputs
// R02: selected port hot-plug follows sink
// R03: unselected port hot-plug held low
// R04: standby: all hot-plug outputs follow sink
// R05: termination only on selected port
// R06: source reads edid after hot-plug high
// R07: source drops address when hot-plug low
// R08: new cec address on each selection
// R09: selection only from host command
// R10: edid in standby keeps control alive
// R11: full cec holds hot-plug high always
// R12: external logic muxes hot-plug per source
// R13: one port active, code map configurable
`ifndef PSH_MAP_VH
`define PSH_MAP_VH
`define PSH_REG_CTRL 4'h0
`define PSH_REG_STAT 4'h4
`define PSH_REG_ADDR 4'h8
`define PSH_REG_OVR 4'hc
`define PSH_CTRL_PORT_LSB 0
`define PSH_CTRL_STBY_BIT 2
`define PSH_CTRL_RST 32'h0000_0004
`define PSH_ADDR_RST 16'hffff
`define PSH_CODE_STBY 2'h2
`define PSH_SETTLE_NS 70
`define PSH_CLK_MHZ 200
`endif

// >>> hw/psh_sel_encode.v
`timescale 1ns/1ps
`include "psh_map.vh"
module psh_sel_encode #(
  parameter [1:0] CODE_P0 = 2'h0,
  parameter [1:0] CODE_P1 = 2'h1,
  parameter [1:0] CODE_P2 = 2'h3
) (
  // request
  input wire [1:0] port_idx,
  input wire standby,
  // pin code
  output reg [1:0] code
);
  // R13 one port code
  always @* begin
    if (standby) begin
      code = `PSH_CODE_STBY;
    end else begin
      case (port_idx)
        2'h0: code = CODE_P0;
        2'h1: code = CODE_P1;
        default: code = CODE_P2;
      endcase
    end
  end
endmodule // psh_sel_encode

// >>> hw/psh_ctrl.v
`timescale 1ns/1ps
`include "psh_map.vh"
module psh_ctrl #(
  parameter NPORTS = 3
) (
  // clock and reset
  input wire clock,
  input wire arst_n,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // switch select pins
  output reg port_select_upper,
  output reg port_select_lower,
  // sink hot-plug seen by the host
  input wire sink_hotplug_in,
  // per-port hot-plug steering for non-sensing sources
  output reg [NPORTS-1:0] hotplug_bypass,
  // cec physical address to load
  output reg [15:0] cec_addr,
  output reg cec_addr_load
);
  localparam integer SETTLE_CYC = (`PSH_SETTLE_NS * `PSH_CLK_MHZ + 999) / 1000;
  localparam [7:0] SETTLE_C = SETTLE_CYC[7:0];
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg [31:0] ctrl_r;
  reg [15:0] addr_r;
  reg [NPORTS-1:0] ovr_r;
  reg state_r;
  reg [7:0] cnt_r;
  reg hp_s1_r;
  reg hp_s2_r;
  reg busy_r;
  reg rd_done_r;
  wire [1:0] code;

  psh_sel_encode u_enc (
    .port_idx(ctrl_r[`PSH_CTRL_PORT_LSB +: 2]),
    .standby(ctrl_r[`PSH_CTRL_STBY_BIT]),
    .code(code)
  );

  // writes take one cycle, reads two
  assign avs_waitrequest = avs_read & ~rd_done_r;

  // R06 sink hot-plug seen
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hp_s1_r <= 1'b0;
      hp_s2_r <= 1'b0;
    end else begin
      hp_s1_r <= sink_hotplug_in;
      hp_s2_r <= hp_s1_r;
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `PSH_CTRL_RST;
      // R07 invalid address default
      addr_r <= `PSH_ADDR_RST;
      ovr_r <= {NPORTS{1'b0}};
      rd_done_r <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_done_r <= avs_read & ~rd_done_r;
      // R09 host-only select
      if (avs_write) begin
        case (avs_address)
          `PSH_REG_CTRL: ctrl_r <= {29'h0, avs_writedata[2:0]};
          `PSH_REG_ADDR: addr_r <= avs_writedata[15:0];
          `PSH_REG_OVR: ovr_r <= avs_writedata[NPORTS-1:0];
          default: ctrl_r <= ctrl_r;
        endcase
      end
      if (avs_read & ~rd_done_r) begin
        case (avs_address)
          `PSH_REG_CTRL: avs_readdata <= ctrl_r;
          `PSH_REG_STAT: avs_readdata <= {28'h0, code, busy_r, hp_s2_r};
          `PSH_REG_ADDR: avs_readdata <= {16'h0, addr_r};
          `PSH_REG_OVR: avs_readdata <= {{(32-NPORTS){1'b0}}, ovr_r};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_select_upper <= 1'b1;
      port_select_lower <= 1'b0;
      state_r <= ST_IDLE;
      cnt_r <= 8'h0;
      busy_r <= 1'b0;
      cec_addr <= `PSH_ADDR_RST;
      cec_addr_load <= 1'b0;
      hotplug_bypass <= {NPORTS{1'b0}};
    end else begin
      cec_addr_load <= 1'b0;
      // R11 R12 hot-plug steering
      hotplug_bypass <= ovr_r;
      case (state_r)
        ST_IDLE: begin
          busy_r <= 1'b0;
          // R01 R10 drive select code
          if ({port_select_upper, port_select_lower} != code) begin
            port_select_upper <= code[1];
            port_select_lower <= code[0];
            cnt_r <= SETTLE_C;
            busy_r <= 1'b1;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cnt_r <= 8'h1) begin
            // R08 new cec address
            cec_addr <= addr_r;
            cec_addr_load <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // psh_ctrl

// >>> bench/psh_dev_model.sv
`timescale 1ns/1ps
module psh_dev_model (
  // select pins and sink hot-plug
  input wire sel_up, input wire sel_lo, input wire sink_hp,
  // per-port outputs and common tri-state
  output logic [2:0] hpd, output logic [2:0] term, output logic tmds_hiz
);
  wire stby = sel_up & ~sel_lo;
  wire [2:0] one = stby ? 3'h0 : (sel_up ? 3'h4 : (sel_lo ? 3'h2 : 3'h1));
  assign tmds_hiz = stby;
  assign term = one;
  assign hpd = stby ? {3{sink_hp}} : one & {3{sink_hp}};
endmodule // psh_dev_model

// >>> bench/psh_ctrl_checker.sv
`timescale 1ns/1ps
module psh_ctrl_checker #(parameter NPORTS = 3) (
  input wire clock, input wire arst_n, input wire [3:0] avs_address, input wire avs_write,
  input wire [31:0] avs_writedata, input wire port_select_upper, input wire port_select_lower,
  input wire [NPORTS-1:0] hotplug_bypass, input wire [15:0] cec_addr, input wire cec_addr_load
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire [1:0] pins = {port_select_upper, port_select_lower};
  wire ctl_wr = avs_write && avs_address == 4'h0;
  // last address written by the host, invalid until the first write
  logic [15:0] last_addr;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      last_addr <= 16'hffff;
    else if (avs_write && avs_address == 4'h8)
      last_addr <= avs_writedata[15:0];
  end
  a_sel_cmd: assert property ($changed(pins) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("select moved without command");
  a_load_after: assert property ($changed(pins) |-> ##[1:40] cec_addr_load)
    else $error("no address load after select change");
  a_load_once: assert property (cec_addr_load |=> !cec_addr_load)
    else $error("address load pulse too long");
  a_bypass_cmd: assert property ($changed(hotplug_bypass) |-> $past(avs_write && avs_address == 4'hc, 2))
    else $error("bypass moved without command");
  a_sel_settle: assert property ($changed(pins) |=> $stable(pins) [*8])
    else $error("select moved while settling");
  a_load_value: assert property (cec_addr_load |-> cec_addr == $past(last_addr))
    else $error("loaded address differs from host write");
  cover property (cec_addr_load);
  cover property (port_select_upper && !port_select_lower);
  cover property ($changed(hotplug_bypass));
endmodule // psh_ctrl_checker
bind psh_ctrl psh_ctrl_checker #(.NPORTS(NPORTS)) i_psh_ctrl_checker (.clock(clock), .arst_n(arst_n),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .port_select_upper(port_select_upper), .port_select_lower(port_select_lower),
  .hotplug_bypass(hotplug_bypass), .cec_addr(cec_addr), .cec_addr_load(cec_addr_load));

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 0, arst_n = 0, rd = 0, wr = 0, hp = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q;
  logic [15:0] ea;
  logic [2:0] eo, et, eh;
  logic [1:0] ec;
  wire [31:0] rdat;
  wire wt, up, lo, ld, hiz;
  wire [2:0] byp, hpd, term;
  wire [15:0] ca;
  integer bad_count = 0, num_checks = 0, i, v, loads = 0;
  psh_ctrl i_psh_ctrl (.clock(clock), .arst_n(arst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt), .port_select_upper(up),
    .port_select_lower(lo), .sink_hotplug_in(hp), .hotplug_bypass(byp), .cec_addr(ca), .cec_addr_load(ld));
  psh_dev_model i_psh_dev_model (.sel_up(up), .sel_lo(lo), .sink_hp(hp), .hpd(hpd), .term(term), .tmds_hiz(hiz));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // count address load pulses
  always @(posedge clock) begin
    if (ld === 1'b1)
      loads++;
  end
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    adr <= a; wd <= d; wr <= w; rd <= !w;
    @(posedge clock);
    while (wt !== 1'b0) @(posedge clock);
    q = rdat; wr <= 0; rd <= 0;
    @(posedge clock);
  endtask
  task finish_test;
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000; bad_count++; finish_test;
  end
  initial begin
    i = $urandom(58498);
    repeat (10) @(posedge clock);
    arst_n <= 1;
    @(posedge clock);
    bus(0, 4'h0, 0); chk(q, 32'h4);
    bus(0, 4'h8, 0); chk(q, 32'hffff);
    for (i = 0; i < 5; i++) begin
      // port 0, 1, 2, standby, then port 2 again via idx 3
      v = i ^ (i > 2 ? 7 : 0);
      ea = $urandom; eo = $urandom; hp <= $urandom;
      bus(1, 4'h8, {16'h0, ea});
      bus(1, 4'h0, v == 4 ? 32'h4 : v);
      repeat (20) @(posedge clock);
      et = v == 4 ? 3'h0 : 3'h1 << (v > 2 ? 2 : v);
      eh = v == 4 ? {3{hp}} : et & {3{hp}};
      chk(ca, ea);
      chk(loads, i + 1);
      chk({hiz, term, hpd}, {v == 4, et, eh});
      ec = v == 4 ? 2'h2 : (v == 0 ? 2'h0 : (v == 1 ? 2'h1 : 2'h3));
      bus(0, 4'h4, 0); chk(q[0], hp);
      chk(q[3:0], {ec, 1'b0, hp});
      bus(1, 4'hc, eo);
      @(posedge clock);
      chk(byp, eo);
    end
    bus(0, 4'h2, 0); chk(q, 0);
    finish_test;
  end
endmodule // tb
